/* File: verilog/hub_port_pkg.sv */
// Package with the port status layout, feature codes and port state encoding.
package hub_port_pkg;
   localparam int           STAT_W       = 16;
   localparam int           FEAT_W       = 8;
   localparam int           BIT_CONN     = 0;
   localparam int           BIT_EN       = 1;
   localparam int           BIT_SUSP     = 2;
   localparam int           BIT_OC       = 3;
   localparam int           BIT_RST      = 4;
   localparam int           BIT_PWR      = 8;
   localparam int           BIT_LOW      = 9;
   localparam int           BIT_HIGH     = 10;
   localparam int           BIT_TEST     = 11;
   localparam int           BIT_IND      = 12;
   localparam logic [15:0]  STAT_RESET   = 16'h0000;
   localparam logic [7:0]   SEL_DEFAULT  = 8'h00;
   localparam logic [7:0]   FEAT_CONN    = 8'h00;
   localparam logic [7:0]   FEAT_EN      = 8'h01;
   localparam logic [7:0]   FEAT_SUSP    = 8'h02;
   localparam logic [7:0]   FEAT_OC      = 8'h03;
   localparam logic [7:0]   FEAT_RST     = 8'h04;
   localparam logic [7:0]   FEAT_PWR     = 8'h08;
   localparam logic [7:0]   FEAT_LOW     = 8'h09;
   localparam logic [7:0]   FEAT_HIGH    = 8'h0A;
   localparam logic [7:0]   FEAT_TEST    = 8'h0B;
   localparam logic [7:0]   FEAT_IND     = 8'h0C;

   typedef enum logic [3:0] {
      PS_POWERED_OFF, PS_DISCONNECTED, PS_DISABLED, PS_ENABLED, PS_RESETTING,
      PS_SPEED_EVAL, PS_SUSPENDED, PS_RESUMING, PS_EOP_SEND, PS_RESTART_SUSP,
      PS_RESTART_END, PS_TRANSMIT, PS_TRANSMIT_RESUME
   } port_state_t;

   typedef enum logic [2:0] {
      ACT_NOOP, ACT_ERROR, ACT_ENABLE, ACT_SUSPEND, ACT_RESET, ACT_POWER,
      ACT_TEST, ACT_IND
   } req_act_t;
endpackage

/* File: verilog/port_req_if.sv */
// Interface carrying a feature request to the decoder and its class back.
`timescale 1ns/1ps
interface port_req_if;
   logic                       valid;
   logic                       set;
   logic [7:0]                 feature;
   hub_port_pkg::req_act_t     act;
   modport ctl (output valid, output set, output feature, input act);
   modport dec (input valid, input set, input feature, output act);
endinterface

/* File: verilog/feature_decoder.sv */
// Classifies a set or clear feature request into the action it takes.
`timescale 1ns/1ps
module feature_decoder (
   port_req_if.dec req
);
   import hub_port_pkg::*;

   function automatic req_act_t classify(input logic set, input logic [7:0] feat);
      req_act_t a;
      a = ACT_ERROR;
      case (feat)
         FEAT_CONN: a = ACT_NOOP;
         FEAT_EN:   a = set ? ACT_ERROR : ACT_ENABLE;
         FEAT_SUSP: a = ACT_SUSPEND;
         FEAT_OC:   a = ACT_NOOP;
         FEAT_RST:  a = set ? ACT_RESET : ACT_NOOP;
         FEAT_PWR:  a = ACT_POWER;
         FEAT_LOW:  a = ACT_NOOP;
         FEAT_HIGH: a = ACT_NOOP;
         FEAT_TEST: a = ACT_TEST;
         FEAT_IND:  a = ACT_IND;
         default:   a = ACT_ERROR;
      endcase
      return a;
   endfunction

   // Gated by valid so an idle bus reads as a no-op; still ready in the request cycle.
   always_comb begin
      req.act = req.valid ? classify(req.set, req.feature) : ACT_NOOP;
   end
endmodule

/* File: verilog/hub_port_status_bits.sv */
// Status word logic for one downstream hub port and its feature requests.
// What this block does
// - Slow-device flag is one for a low-speed attached device.
// - Fast-device flag, bit 10, is one for high speed, zero full speed.
// - Test-mode flag in bit 11, changed by set and clear feature.
// - Lamp-override flag in bit 12 shows software-controlled indicator colour.
// - Reserved status bits 13 to 15 always read zero.
// - While powered, attached flag follows whether a device is present.
// - Attached flag clears when powered off or disconnected, sets on attach.
// - Feature requests on the attached flag are no-operations.
// - Port-active flag sets only on leaving resetting or speed check.
// - Port-active clears on power off, clear request, fault, disconnect, reset.
// - Set-feature on the port-active flag is answered with a request error.
// - Port-active means the port may carry packets and resume signaling.
// - Sleep flag sets on suspend request only while port-active is one.
// - While asleep, downstream traffic is blocked; resume from port still served.
// - Sleep flag clears on end-of-packet or restart exits, or losing active.
// - Overload flag follows an over-current on this port.
// - Over-current on another port affecting this one also sets overload.
// - Feature requests on the overload flag are no-operations.
// - Port-reinit flag is one in resetting; set-feature reset starts it.
// - Port-reinit flag is zero while powered off.
// - Clear-feature on the port-reinit flag is a no-operation.
// - Over-current detection is always present for a self-powered hub.
// - Get-status returns four bytes: status word then change word.
`timescale 1ns/1ps
module hub_port_status_bits (
   input  wire logic                       I_CORE_CLK,
   input  wire logic                       I_RST_N,
   input  wire logic                       I_REQ_VALID,
   input  wire logic                       I_REQ_SET,
   input  wire logic [7:0]                 I_REQ_FEATURE,
   input  wire logic [7:0]                 I_REQ_SELECTOR,
   input  wire logic                       I_STAT_REQ,
   input  wire logic [15:0]                I_CHANGE_WORD,
   input  wire hub_port_pkg::port_state_t  I_PORT_STATE,
   input  wire logic                       I_PORT_ERROR,
   input  wire logic                       I_SPEED_LOW,
   input  wire logic                       I_SPEED_HIGH,
   input  wire logic                       I_ATTACH_DET,
   input  wire logic                       I_OC_LOCAL,
   input  wire logic                       I_OC_OTHER,
   output logic [15:0]                     O_PORT_STATUS,
   output logic                            O_STAT_VALID,
   output logic [31:0]                     O_STAT_DATA,
   output logic                            O_REQ_DONE,
   output logic                            O_REQ_ERR,
   output logic                            O_RESET_REQ,
   output logic                            O_DISABLE_REQ,
   output logic                            O_RESUME_REQ,
   output logic                            O_PWR_ON_REQ,
   output logic                            O_PWR_OFF_REQ,
   output logic                            O_SUSPEND,
   output logic                            O_FORWARD_EN,
   output logic                            O_TEST_MODE,
   output logic [7:0]                      O_TEST_SEL,
   output logic [7:0]                      O_IND_SEL
);
   import hub_port_pkg::*;

   port_req_if req ();
   port_state_t prev_reg;
   logic [1:0]  attach_sync_reg;
   logic [1:0]  ocl_sync_reg;
   logic [1:0]  oco_sync_reg;
   logic        conn_reg;
   logic        en_reg;
   logic        susp_reg;
   logic        oc_reg;
   logic        rst_reg;
   logic        pwr_reg;
   logic        low_reg;
   logic        high_reg;
   logic        test_reg;
   logic        ind_reg;
   logic        en_clear;
   logic        en_set;
   logic        susp_exit;
   logic        do_req;
   logic        reset_ok;
   logic        test_ok;

   assign req.valid   = I_REQ_VALID;
   assign req.set     = I_REQ_SET;
   assign req.feature = I_REQ_FEATURE;

   feature_decoder u_dec (
      .req (req)
   );

   function automatic logic in_reset_phase(input port_state_t s);
      return (s == PS_RESETTING) || (s == PS_SPEED_EVAL);
   endfunction

   // Pins from the port pads come from outside the clock domain.
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         attach_sync_reg <= 2'h0;
         ocl_sync_reg    <= 2'h0;
         oco_sync_reg    <= 2'h0;
         prev_reg        <= PS_POWERED_OFF;
      end else begin
         attach_sync_reg <= {attach_sync_reg[0], I_ATTACH_DET};
         ocl_sync_reg    <= {ocl_sync_reg[0], I_OC_LOCAL};
         oco_sync_reg    <= {oco_sync_reg[0], I_OC_OTHER};
         prev_reg        <= I_PORT_STATE;
      end
   end

   assign do_req   = I_REQ_VALID && I_REQ_SET;
   assign reset_ok = (I_PORT_STATE != PS_POWERED_OFF) && conn_reg;
   assign test_ok  = (I_PORT_STATE == PS_DISABLED) || (I_PORT_STATE == PS_DISCONNECTED) ||
                     (I_PORT_STATE == PS_SUSPENDED);

   // Any event that drops port-active; a clear request loses to a reset exit.
   assign en_set   = in_reset_phase(prev_reg) && (I_PORT_STATE == PS_ENABLED);
   assign en_clear = (I_PORT_STATE == PS_POWERED_OFF) ||
                     (I_PORT_STATE == PS_DISCONNECTED) || I_PORT_ERROR ||
                     (I_REQ_VALID && !I_REQ_SET && req.act == ACT_ENABLE) ||
                     (do_req && req.act == ACT_RESET && reset_ok);
   assign susp_exit = ((prev_reg == PS_EOP_SEND) && (I_PORT_STATE == PS_ENABLED)) ||
                      ((prev_reg == PS_RESTART_SUSP) && (I_PORT_STATE == PS_TRANSMIT));

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         conn_reg <= 1'b0;
      end else if ((I_PORT_STATE == PS_POWERED_OFF) || (I_PORT_STATE == PS_DISCONNECTED)) begin
         conn_reg <= 1'b0;
      end else if ((prev_reg == PS_DISCONNECTED) && (I_PORT_STATE == PS_DISABLED) &&
                   attach_sync_reg[1]) begin
         conn_reg <= 1'b1;
      end else if (!attach_sync_reg[1]) begin
         conn_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         en_reg <= 1'b0;
      end else if (en_set) begin
         en_reg <= 1'b1;
      end else if (en_clear) begin
         en_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         susp_reg <= 1'b0;
      end else if (susp_exit || (en_clear && !en_set)) begin
         susp_reg <= 1'b0;
      end else if (do_req && req.act == ACT_SUSPEND && en_reg) begin
         susp_reg <= 1'b1;
      end
   end

   // Detection is built in unconditionally, so a self-powered build never lacks it.
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         oc_reg <= 1'b0;
      end else begin
         oc_reg <= ocl_sync_reg[1] || oco_sync_reg[1];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_reg  <= 1'b0;
         pwr_reg  <= 1'b0;
         low_reg  <= 1'b0;
         high_reg <= 1'b0;
      end else begin
         rst_reg  <= (I_PORT_STATE == PS_RESETTING);
         pwr_reg  <= (I_PORT_STATE != PS_POWERED_OFF);
         low_reg  <= conn_reg && I_SPEED_LOW;
         high_reg <= conn_reg && !I_SPEED_LOW && I_SPEED_HIGH;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         test_reg   <= 1'b0;
         O_TEST_SEL <= SEL_DEFAULT;
      end else if (I_REQ_VALID && req.act == ACT_TEST) begin
         if (!I_REQ_SET) begin
            test_reg <= 1'b0;
         end else if (test_ok) begin
            test_reg   <= 1'b1;
            O_TEST_SEL <= I_REQ_SELECTOR;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ind_reg   <= 1'b0;
         O_IND_SEL <= SEL_DEFAULT;
      end else if (I_REQ_VALID && req.act == ACT_IND) begin
         ind_reg   <= I_REQ_SET && (I_REQ_SELECTOR != SEL_DEFAULT);
         O_IND_SEL <= I_REQ_SET ? I_REQ_SELECTOR : SEL_DEFAULT;
      end
   end

   // Request answers and the one-cycle commands to the port state machine.
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REQ_DONE    <= 1'b0;
         O_REQ_ERR     <= 1'b0;
         O_RESET_REQ   <= 1'b0;
         O_DISABLE_REQ <= 1'b0;
         O_RESUME_REQ  <= 1'b0;
         O_PWR_ON_REQ  <= 1'b0;
         O_PWR_OFF_REQ <= 1'b0;
      end else begin
         O_REQ_DONE    <= I_REQ_VALID;
         O_REQ_ERR     <= I_REQ_VALID && ((req.act == ACT_ERROR) ||
                          (do_req && req.act == ACT_RESET && !reset_ok) ||
                          (do_req && req.act == ACT_TEST && !test_ok));
         O_RESET_REQ   <= do_req && req.act == ACT_RESET && reset_ok;
         O_DISABLE_REQ <= I_REQ_VALID && !I_REQ_SET && req.act == ACT_ENABLE;
         O_RESUME_REQ  <= I_REQ_VALID && !I_REQ_SET && req.act == ACT_SUSPEND && susp_reg;
         O_PWR_ON_REQ  <= do_req && req.act == ACT_POWER;
         O_PWR_OFF_REQ <= I_REQ_VALID && !I_REQ_SET && req.act == ACT_POWER;
      end
   end

   always_comb begin
      O_PORT_STATUS           = STAT_RESET;
      O_PORT_STATUS[BIT_CONN] = conn_reg;
      O_PORT_STATUS[BIT_EN]   = en_reg;
      O_PORT_STATUS[BIT_SUSP] = susp_reg;
      O_PORT_STATUS[BIT_OC]   = oc_reg;
      O_PORT_STATUS[BIT_RST]  = rst_reg;
      O_PORT_STATUS[BIT_PWR]  = pwr_reg;
      O_PORT_STATUS[BIT_LOW]  = low_reg;
      O_PORT_STATUS[BIT_HIGH] = high_reg;
      O_PORT_STATUS[BIT_TEST] = test_reg;
      O_PORT_STATUS[BIT_IND]  = ind_reg;
   end

   // Resume detection elsewhere is never gated by this, only downstream traffic.
   assign O_FORWARD_EN = en_reg && !susp_reg;
   assign O_SUSPEND    = susp_reg;
   assign O_TEST_MODE  = test_reg;

   // One register load takes every flag at once, so the reply cannot tear.
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_STAT_VALID <= 1'b0;
         O_STAT_DATA  <= 32'h0000_0000;
      end else begin
         O_STAT_VALID <= I_STAT_REQ;
         if (I_STAT_REQ) begin
            O_STAT_DATA <= {I_CHANGE_WORD, O_PORT_STATUS};
         end
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   reserved_zero_a: assert property (O_PORT_STATUS[15:13] == 3'h0 &&
      O_PORT_STATUS[7:5] == 3'h0) else $error("reserved status bits not zero");
   reinit_state_a: assert property ((I_PORT_STATE == PS_RESETTING) |=>
      O_PORT_STATUS[BIT_RST]) else $error("reinit flag missing in resetting");
   poweroff_clear_a: assert property ((I_PORT_STATE == PS_POWERED_OFF) |=>
      !O_PORT_STATUS[BIT_RST] && !conn_reg && !en_reg) else $error("flags set while off");
   enable_source_a: assert property ($rose(en_reg) |->
      in_reset_phase($past(prev_reg, 1))) else $error("port-active set outside reset exit");
   sleep_needs_active_a: assert property ($rose(susp_reg) |-> $past(en_reg))
      else $error("sleep flag set while not active");
   sleep_drop_a: assert property ($fell(en_reg) |-> !susp_reg)
      else $error("sleep flag outlived port-active");
   overload_track_a: assert property ($rose(I_OC_LOCAL) ##1 I_OC_LOCAL [*2] |=>
      O_PORT_STATUS[BIT_OC]) else $error("overload flag late");
   overload_other_a: assert property ($rose(I_OC_OTHER) ##1 I_OC_OTHER [*2] |=>
      O_PORT_STATUS[BIT_OC]) else $error("shared overload not reported");
   attach_noop_a: assert property (I_REQ_VALID && I_REQ_FEATURE == FEAT_CONN |=>
      O_REQ_DONE && !O_REQ_ERR) else $error("attach request not a no-op");
   set_active_err_a: assert property (I_REQ_VALID && I_REQ_SET &&
      I_REQ_FEATURE == FEAT_EN |=> O_REQ_ERR && $stable(en_reg))
      else $error("set port-active not refused");
   forward_gate_a: assert property (I_REQ_VALID && I_REQ_SET &&
      I_REQ_FEATURE == FEAT_SUSP && O_PORT_STATUS[BIT_EN] && prev_reg == I_PORT_STATE
      |=> !O_FORWARD_EN) else $error("traffic forwarded while blocked");
   speed_flags_a: assert property (O_PORT_STATUS[BIT_HIGH] |->
      !O_PORT_STATUS[BIT_LOW]) else $error("both speed flags set");
   slow_flag_a: assert property (O_PORT_STATUS[BIT_LOW] |-> $past(conn_reg))
      else $error("slow flag without device");
   lamp_clear_a: assert property (I_REQ_VALID && !I_REQ_SET &&
      I_REQ_FEATURE == FEAT_IND |=> !O_PORT_STATUS[BIT_IND]) else $error("lamp flag kept");
   test_clear_a: assert property (I_REQ_VALID && !I_REQ_SET &&
      I_REQ_FEATURE == FEAT_TEST |=> !O_TEST_MODE) else $error("test flag kept");
   snapshot_a: assert property (I_STAT_REQ |=> O_STAT_VALID &&
      O_STAT_DATA[15:0] == $past(O_PORT_STATUS) && O_STAT_DATA[31:16] == $past(I_CHANGE_WORD))
      else $error("status reply does not match snapshot");

   active_rise_c: cover property ($rose(en_reg));
   sleep_rise_c: cover property ($rose(susp_reg));
   reset_cmd_c: cover property (O_RESET_REQ);
   reply_c: cover property (O_STAT_VALID && O_STAT_DATA[BIT_EN]);
endmodule

/* File: verif/port_fsm_model.sv */
// Behavioural port state machine that answers the block's pulses.
`timescale 1ns/1ps
module port_fsm_model (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_reset_req,
   input  wire logic                       i_pwr_on_req,
   input  wire logic                       i_pwr_off_req,
   input  wire logic                       i_disable_req,
   input  wire logic                       i_attach,
   input  wire logic                       i_jump,
   input  wire hub_port_pkg::port_state_t  i_jump_state,
   output hub_port_pkg::port_state_t       o_state
);
   import hub_port_pkg::*;

   logic [2:0] cnt_reg;
   // The bench jump overrides all so odd state pairs can be staged on demand.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_state <= PS_POWERED_OFF;
         cnt_reg <= 3'h0;
      end else if (i_jump) begin
         o_state <= i_jump_state;
      end else if (i_pwr_off_req) begin
         o_state <= PS_POWERED_OFF;
      end else if (i_pwr_on_req) begin
         o_state <= PS_DISCONNECTED;
      end else if (i_reset_req) begin
         o_state <= PS_RESETTING;
         cnt_reg <= 3'h4;
      end else if (i_disable_req) begin
         o_state <= PS_DISABLED;
      end else if (o_state == PS_DISCONNECTED && i_attach) begin
         o_state <= PS_DISABLED;
      end else if (o_state == PS_RESETTING) begin
         if (cnt_reg == 3'h0) begin
            o_state <= PS_ENABLED;
         end else begin
            cnt_reg <= cnt_reg - 3'h1;
         end
      end
   end
endmodule

/* File: verif/tb_hub_port_status_bits.sv */
// Self-checking bench for the port status word logic.
`timescale 1ns/1ps
module tb_hub_port_status_bits;
   import hub_port_pkg::*;
   logic clk, rst_n, rv, rs, sq, pe, sl, sh, at, ol, oo, jmp;
   logic [7:0]  rf, rsel;
   logic [15:0] cw, st;
   logic [31:0] sd;
   logic sv, dn, er, rreq, dreq, onr, offr, susp, fwd, tm, rsm, rsm_cap;
   logic [7:0]  tsel, isel;
   logic [1:0]  ans;
   port_state_t ps, js;
   int miscompares, num_checks, cyc;
   hub_port_status_bits i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REQ_VALID(rv),
      .I_REQ_SET(rs), .I_REQ_FEATURE(rf), .I_REQ_SELECTOR(rsel), .I_STAT_REQ(sq),
      .I_CHANGE_WORD(cw), .I_PORT_STATE(ps), .I_PORT_ERROR(pe), .I_SPEED_LOW(sl),
      .I_SPEED_HIGH(sh), .I_ATTACH_DET(at), .I_OC_LOCAL(ol), .I_OC_OTHER(oo),
      .O_PORT_STATUS(st), .O_STAT_VALID(sv), .O_STAT_DATA(sd), .O_REQ_DONE(dn),
      .O_REQ_ERR(er), .O_RESET_REQ(rreq), .O_DISABLE_REQ(dreq), .O_RESUME_REQ(rsm),
      .O_PWR_ON_REQ(onr), .O_PWR_OFF_REQ(offr), .O_SUSPEND(susp), .O_FORWARD_EN(fwd),
      .O_TEST_MODE(tm), .O_TEST_SEL(tsel), .O_IND_SEL(isel));
   port_fsm_model i_model (.i_clk(clk), .i_rst_n(rst_n), .i_reset_req(rreq),
      .i_pwr_on_req(onr), .i_pwr_off_req(offr), .i_disable_req(dreq), .i_attach(at),
      .i_jump(jmp), .i_jump_state(js), .o_state(ps));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // A hang is cut after a bound far above the whole sequence.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One request for one edge; the answer is taken after it drops, then one idle edge passes.
   task automatic req(input logic s, input logic [7:0] f, input logic [7:0] sel);
      int n;
      n = 0;
      rv = 1'b1;
      rs = s;
      rf = f;
      rsel = sel;
      tick(1);
      rv = 1'b0;
      while (dn !== 1'b1 && n < 3) begin
         tick(1);
         n++;
      end
      ans = {dn, er};
      rsm_cap = rsm;
      tick(1);
   endtask
   task automatic go(input port_state_t s);
      jmp = 1'b1;
      js = s;
      tick(1);
      jmp = 1'b0;
      tick(1);
   endtask
   task automatic t_reset();
      chk(32'(st), 32'h0000_0000);
      chk(32'({susp, fwd, tm, sv, dn, rsm}), 32'h0000_0000);
   endtask
   task automatic t_attach();
      at = 1'b1;
      sh = 1'b1;
      tick(4);
      req(1'b1, FEAT_PWR, 8'h00);
      tick(4);
      chk(32'(st[0]), 32'h1);
      chk(32'(st[10:9]), 32'h2);
      req(1'b0, FEAT_CONN, 8'h00);
      chk(32'(ans), 32'h2);
      chk(32'(st[0]), 32'h1);
      sl = 1'b1;
      tick(2);
      chk(32'(st[10:9]), 32'h1);
      sl = 1'b0;
      tick(1);
      chk(32'(st[10:9]), 32'h2);
   endtask
   task automatic t_stat();
      sq = 1'b1;
      cw = 16'hA5C3;
      tick(1);
      cw = 16'h3C5A;
      chk(32'(sv), 32'h1);
      chk(sd, 32'hA5C3_0501);
      tick(1);
      sq = 1'b0;
      chk(32'(sv), 32'h1);
      chk(sd, 32'h3C5A_0501);
      tick(1);
      chk(32'(sv), 32'h0);
      chk(sd, 32'h3C5A_0501);
   endtask
   task automatic t_enable();
      req(1'b1, FEAT_EN, 8'h00);
      chk(32'({ans, st[1]}), 32'h6);
      req(1'b1, FEAT_SUSP, 8'h00);
      chk(32'({ans, st[2]}), 32'h4);
      req(1'b1, FEAT_RST, 8'h00);
      tick(2);
      chk(32'(st[4:1]), 32'h8);
      tick(6);
      chk(32'({st[4:1], fwd}), 32'h3);
   endtask
   task automatic t_sleep();
      req(1'b1, FEAT_SUSP, 8'h00);
      chk(32'({st[2], susp, fwd}), 32'h6);
      req(1'b0, FEAT_SUSP, 8'h00);
      chk(32'({ans, rsm_cap, susp}), 32'hB);
      go(PS_EOP_SEND);
      go(PS_ENABLED);
      chk(32'({st[2], susp, fwd}), 32'h1);
      req(1'b1, FEAT_SUSP, 8'h00);
      go(PS_RESTART_SUSP);
      go(PS_TRANSMIT);
      chk(32'(st[2]), 32'h0);
      go(PS_ENABLED);
      req(1'b1, FEAT_SUSP, 8'h00);
      req(1'b0, FEAT_EN, 8'h00);
      chk(32'({ans, st[2:1]}), 32'h8);
      t_enable();
      pe = 1'b1;
      tick(1);
      pe = 1'b0;
      tick(1);
      chk(32'({st[1], fwd}), 32'h0);
   endtask
   task automatic t_ovl();
      ol = 1'b1;
      tick(3);
      chk(32'(st[3]), 32'h1);
      req(1'b0, FEAT_OC, 8'h00);
      chk(32'({ans, st[3]}), 32'h5);
      oo = 1'b1;
      ol = 1'b0;
      tick(4);
      chk(32'(st[3]), 32'h1);
      oo = 1'b0;
      tick(4);
      chk(32'(st[3]), 32'h0);
   endtask
   task automatic t_test();
      req(1'b0, FEAT_RST, 8'h00);
      chk(32'({ans, st[4]}), 32'h4);
      req(1'b0, FEAT_SUSP, 8'h00);
      chk(32'({ans, rsm_cap}), 32'h4);
      go(PS_ENABLED);
      req(1'b1, FEAT_TEST, 8'h04);
      chk(32'({ans, st[11], tm}), 32'hC);
      go(PS_DISABLED);
      req(1'b1, FEAT_TEST, 8'h04);
      chk(32'({ans, st[11], tm, tsel}), 32'h0000_0B04);
      req(1'b0, FEAT_TEST, 8'h00);
      chk(32'({st[11], tm}), 32'h0);
      req(1'b1, FEAT_IND, 8'h02);
      chk(32'({ans, st[12], isel}), 32'h0000_0502);
      req(1'b1, FEAT_IND, 8'h00);
      chk(32'(st[12]), 32'h0);
      req(1'b1, FEAT_IND, 8'h05);
      req(1'b0, FEAT_IND, 8'h00);
      chk(32'({st[12], isel}), 32'h0);
      req(1'b1, 8'h07, 8'h00);
      chk(32'(ans), 32'h3);
   endtask
   task automatic t_off();
      req(1'b0, FEAT_PWR, 8'h00);
      tick(3);
      chk(32'({st[8], st[4], st[1:0]}), 32'h0);
   endtask
   initial begin
      {rv, rs, sq, pe, sl, sh, at, ol, oo, jmp} = '0;
      rf = 8'h00; rsel = 8'h00; cw = 16'h0000; js = PS_POWERED_OFF;
      miscompares = 0; num_checks = 0; cyc = 0;
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(1);
      t_reset();
      t_attach();
      t_stat();
      t_enable();
      t_sleep();
      t_ovl();
      t_test();
      t_off();
      final_report();
   end
endmodule
